// ===== common/drc_pkg.sv
// constants and types shared by the disturbance recorder control block
package drc_pkg;
	// ------------------------------------------------------------
	// register bus shape
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int SIG_W  = 8;
	localparam int MAX_CH = 8;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [3:0] REG_STATUS   = 4'h0; // recorder_status_param
	localparam logic [3:0] REG_MANTRIG  = 4'h1; // manual_trigger_param
	localparam logic [3:0] REG_CLRARM   = 4'h2; // clear_and_arm_param
	localparam logic [3:0] REG_EVMASK   = 4'h3; // recorder_event_mask_param
	localparam logic [3:0] REG_SRC_A    = 4'h4; // trigger_source_select_a
	localparam logic [3:0] REG_SRC_B    = 4'h5; // trigger_source_select_b
	localparam logic [3:0] REG_EDGE_A   = 4'h6; // trigger_edge_select_a
	localparam logic [3:0] REG_EDGE_B   = 4'h7; // trigger_edge_select_b
	localparam logic [3:0] REG_POSTLEN  = 4'h8; // post_trigger_length_param
	localparam logic [3:0] REG_RATE     = 4'h9; // sampling_rate_param
	localparam logic [3:0] REG_CH_INT   = 4'ha; // channel_select_internal
	localparam logic [3:0] REG_CH_DIN   = 4'hb; // channel_select_inputs
	localparam logic [3:0] REG_PREREQ1  = 4'hc; // unload_prereq_first
	localparam logic [3:0] REG_PREREQ2  = 4'hd; // unload_prereq_second
	localparam logic [3:0] REG_LEDROUTE = 4'he;
	localparam logic [3:0] REG_STATE    = 4'hf;
	// ------------------------------------------------------------
	// values, codes and reset values
	// ------------------------------------------------------------
	localparam logic [15:0] STATUS_IDLE   = 16'h0000;
	localparam logic [15:0] STATUS_READY  = 16'h0001;
	localparam logic [15:0] CMD_TRIGGER   = 16'h0001;
	localparam logic [15:0] CMD_CLEAR     = 16'h0001;
	localparam logic [15:0] CMD_RESTART   = 16'h0002;
	localparam logic [7:0]  EV_TRIGGER    = 8'h1f; // trigger_event_code
	localparam logic [7:0]  EV_CLEAR      = 8'h20; // clear_event_code
	localparam int          MASK_TRIG_BIT = 0;
	localparam int          MASK_CLR_BIT  = 1;
	localparam logic [15:0] EVMASK_RESET  = 16'h0003;
	localparam logic [15:0] POSTLEN_RESET = 16'h0010;
	localparam logic [1:0]  RATE_HI       = 2'h0;
	localparam logic [1:0]  RATE_MID      = 2'h1;
	localparam logic [1:0]  RATE_RMS      = 2'h2;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ      = 100_000_000;
	localparam int RATE_HI_HZ  = 800;
	localparam int RATE_MID_HZ = 400;
	localparam int RATE_RMS_HZ = 50;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic       valid;
		logic [7:0] code;
	} drc_event_t;
	typedef enum logic [2:0] {
		ST_ARMED = 3'b001,
		ST_POST  = 3'b010,
		ST_READY = 3'b100
	} drc_state_t;
endpackage

// ===== logic/drc_recorder_ctrl.sv
// disturbance recorder trigger, status and event control
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module drc_recorder_ctrl #(
	parameter int DIV_HI  = drc_pkg::CLK_HZ / drc_pkg::RATE_HI_HZ,
	parameter int DIV_MID = drc_pkg::CLK_HZ / drc_pkg::RATE_MID_HZ,
	parameter int DIV_RMS = drc_pkg::CLK_HZ / drc_pkg::RATE_RMS_HZ
) (
	// clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        rst,
	// register port
	input  wire logic [drc_pkg::ADDR_W-1:0]  regAddr,
	input  wire logic [drc_pkg::DATA_W-1:0]  regWdata,
	input  wire logic                        regWr,
	input  wire logic                        regRd,
	output logic      [drc_pkg::DATA_W-1:0]  regRdata,
	// monitored signals and system
	input  wire logic [drc_pkg::SIG_W-1:0]   intSig,
	input  wire logic [drc_pkg::SIG_W-1:0]   dinSig,
	input  wire logic                        masterReset,
	input  wire logic                        displayIdle,
	// recorder side
	output drc_pkg::drc_event_t              evOut,
	output logic                             memErase,
	output logic                             unloadRestart,
	output logic                             unloadReady,
	output logic      [drc_pkg::MAX_CH-1:0]  recSample,
	output logic                             recSampleValid,
	// indication
	output logic                             readyMarker,
	output logic      [drc_pkg::SIG_W-1:0]   ledReady
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// first eight selected signals, internal ones are taken first, into the lowest bits
	function automatic logic [drc_pkg::MAX_CH-1:0] pickChannels(
		input logic [2*drc_pkg::SIG_W-1:0] vals,
		input logic [2*drc_pkg::SIG_W-1:0] sel
	);
		logic [drc_pkg::MAX_CH-1:0] r;
		int                         n;
		r = '0;
		n = 0;
		for (int i = 0; i < 2*drc_pkg::SIG_W; i++) begin
			if (sel[i] && n < drc_pkg::MAX_CH) begin
				r[n[2:0]] = vals[i];
				n++;
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	drc_pkg::drc_state_t         state;
	logic [drc_pkg::DATA_W-1:0]  evMask;
	logic [drc_pkg::SIG_W-1:0]   srcA, srcB, edgeA, edgeB, chInt, chDin, ledRoute;
	logic [drc_pkg::DATA_W-1:0]  postLen;
	logic [1:0]                  rate;
	logic                        prereq1, prereq2;
	logic                        armed;

	assign armed = (state == drc_pkg::ST_ARMED);

	// plain settings, writable at any time
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			evMask   <= drc_pkg::EVMASK_RESET;
			srcA     <= '0;
			srcB     <= '0;
			edgeA    <= '0;
			edgeB    <= '0;
			postLen  <= drc_pkg::POSTLEN_RESET;
			prereq1  <= 1'b0;
			prereq2  <= 1'b0;
			ledRoute <= '0;
		end else if (regWr) begin
			case (regAddr)
				drc_pkg::REG_EVMASK:   evMask   <= regWdata;
				drc_pkg::REG_SRC_A:    srcA     <= regWdata[drc_pkg::SIG_W-1:0];
				drc_pkg::REG_SRC_B:    srcB     <= regWdata[drc_pkg::SIG_W-1:0];
				drc_pkg::REG_EDGE_A:   edgeA    <= regWdata[drc_pkg::SIG_W-1:0];
				drc_pkg::REG_EDGE_B:   edgeB    <= regWdata[drc_pkg::SIG_W-1:0];
				drc_pkg::REG_POSTLEN:  postLen  <= regWdata;
				drc_pkg::REG_PREREQ1:  prereq1  <= regWdata[0];
				drc_pkg::REG_PREREQ2:  prereq2  <= regWdata[0];
				drc_pkg::REG_LEDROUTE: ledRoute <= regWdata[drc_pkg::SIG_W-1:0];
				default: ;
			endcase
		end
	end

	// recording shape is frozen once triggered, else stored data mixes layouts
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rate  <= drc_pkg::RATE_HI;
			chInt <= '0;
			chDin <= '0;
		end else if (regWr && armed) begin
			if (regAddr == drc_pkg::REG_RATE)
				rate <= regWdata[1:0];
			if (regAddr == drc_pkg::REG_CH_INT)
				chInt <= regWdata[drc_pkg::SIG_W-1:0];
			if (regAddr == drc_pkg::REG_CH_DIN)
				chDin <= regWdata[drc_pkg::SIG_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// sample tick
	// ------------------------------------------------------------
	logic [31:0] divCnt;
	logic [31:0] divEnd;
	logic        tick;

	always_comb begin
		case (rate)
			drc_pkg::RATE_MID: divEnd = 32'(DIV_MID - 1);
			drc_pkg::RATE_RMS: divEnd = 32'(DIV_RMS - 1);
			default:           divEnd = 32'(DIV_HI - 1);
		endcase
	end
	assign tick = (divCnt >= divEnd);

	// free-running divider, restarts at the end of each interval
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			divCnt <= '0;
		else if (tick)
			divCnt <= '0;
		else
			divCnt <= divCnt + 32'h1;
	end

	// ------------------------------------------------------------
	// trigger detection
	// ------------------------------------------------------------
	logic [2*drc_pkg::SIG_W-1:0] cur, prev, srcSel, edgeSel, hits;
	logic                        clearReq, manTrig, trigReq;

	assign cur     = {dinSig, intSig};
	assign srcSel  = {srcB, srcA};
	assign edgeSel = {edgeB, edgeA};
	// edge bit 0 selects rising, 1 selects falling
	assign hits = srcSel & ((cur & ~prev & ~edgeSel) | (~cur & prev & edgeSel));

	// previous value taken only at the sample tick
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			prev <= '0;
		else if (tick)
			prev <= cur;
	end

	assign clearReq = masterReset
		| (regWr && regAddr == drc_pkg::REG_CLRARM && regWdata == drc_pkg::CMD_CLEAR);
	assign manTrig = regWr && regAddr == drc_pkg::REG_MANTRIG
		&& regWdata == drc_pkg::CMD_TRIGGER;
	// clear wins over a trigger in the same cycle
	assign trigReq = (manTrig | (tick && |hits)) && armed && !clearReq;

	// ------------------------------------------------------------
	// recorder state
	// ------------------------------------------------------------
	logic [drc_pkg::DATA_W-1:0] postCnt;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state   <= drc_pkg::ST_ARMED;
			postCnt <= '0;
		end else if (clearReq) begin
			state   <= drc_pkg::ST_ARMED;
			postCnt <= '0;
		end else begin
			case (state)
				drc_pkg::ST_ARMED: if (trigReq) begin
					state   <= drc_pkg::ST_POST;
					postCnt <= '0;
				end
				drc_pkg::ST_POST: if (tick) begin
					if (postCnt >= postLen)
						state <= drc_pkg::ST_READY;
					else
						postCnt <= postCnt + 16'h1;
				end
				drc_pkg::ST_READY: ;
				default: state <= drc_pkg::ST_ARMED;
			endcase
		end
	end

	// ------------------------------------------------------------
	// events and recorder strobes
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			evOut <= '0;
		end else if (clearReq && evMask[drc_pkg::MASK_CLR_BIT]) begin
			evOut <= '{valid: 1'b1, code: drc_pkg::EV_CLEAR};
		end else if (trigReq && evMask[drc_pkg::MASK_TRIG_BIT]) begin
			evOut <= '{valid: 1'b1, code: drc_pkg::EV_TRIGGER};
		end else begin
			evOut <= '0;
		end
	end

	// sampling stops once the recording is complete
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			memErase       <= 1'b0;
			unloadRestart  <= 1'b0;
			recSample      <= '0;
			recSampleValid <= 1'b0;
		end else begin
			memErase       <= clearReq;
			unloadRestart  <= regWr && regAddr == drc_pkg::REG_STATUS
				&& regWdata == drc_pkg::CMD_RESTART;
			recSampleValid <= tick && state != drc_pkg::ST_READY;
			if (tick)
				recSample <= pickChannels(cur, {chDin, chInt});
		end
	end

	// ------------------------------------------------------------
	// indication and read port
	// ------------------------------------------------------------
	logic ready;

	assign ready = (state == drc_pkg::ST_READY);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			readyMarker <= 1'b0;
			ledReady    <= '0;
			unloadReady <= 1'b0;
		end else begin
			readyMarker <= ready && displayIdle;
			ledReady    <= ready ? ledRoute : '0;
			unloadReady <= ready && prereq1 && prereq2;
		end
	end

	// command registers read back as zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			regRdata <= '0;
		end else if (regRd) begin
			case (regAddr)
				drc_pkg::REG_STATUS:   regRdata <= ready ? drc_pkg::STATUS_READY
					: drc_pkg::STATUS_IDLE;
				drc_pkg::REG_EVMASK:   regRdata <= evMask;
				drc_pkg::REG_SRC_A:    regRdata <= {8'h00, srcA};
				drc_pkg::REG_SRC_B:    regRdata <= {8'h00, srcB};
				drc_pkg::REG_EDGE_A:   regRdata <= {8'h00, edgeA};
				drc_pkg::REG_EDGE_B:   regRdata <= {8'h00, edgeB};
				drc_pkg::REG_POSTLEN:  regRdata <= postLen;
				drc_pkg::REG_RATE:     regRdata <= {14'h0000, rate};
				drc_pkg::REG_CH_INT:   regRdata <= {8'h00, chInt};
				drc_pkg::REG_CH_DIN:   regRdata <= {8'h00, chDin};
				drc_pkg::REG_PREREQ1:  regRdata <= {15'h0000, prereq1};
				drc_pkg::REG_PREREQ2:  regRdata <= {15'h0000, prereq2};
				drc_pkg::REG_LEDROUTE: regRdata <= {8'h00, ledRoute};
				drc_pkg::REG_STATE:    regRdata <= {13'h0000, state};
				default:               regRdata <= '0;
			endcase
		end else begin
			regRdata <= '0;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	status_read_a: assert property (regRd && regAddr == drc_pkg::REG_STATUS |=>
		regRdata == ($past(ready) ? drc_pkg::STATUS_READY : drc_pkg::STATUS_IDLE))
		else $error("status read wrong");
	trig_event_a: assert property (trigReq && evMask[drc_pkg::MASK_TRIG_BIT] |=>
		evOut.valid && evOut.code == drc_pkg::EV_TRIGGER)
		else $error("trigger event missing");
	clear_event_a: assert property (clearReq && evMask[drc_pkg::MASK_CLR_BIT] |=>
		evOut.valid && evOut.code == drc_pkg::EV_CLEAR)
		else $error("clear event missing");
	event_mask_a: assert property (!(clearReq && evMask[drc_pkg::MASK_CLR_BIT])
		&& !(trigReq && evMask[drc_pkg::MASK_TRIG_BIT]) |=> !evOut.valid)
		else $error("event without cause");
	clear_arm_a: assert property (clearReq |=> armed && memErase ##1 !readyMarker)
		else $error("clear did not re-arm");
	trig_ignore_a: assert property (ready && !clearReq |=> ready)
		else $error("triggered state left");
	restart_a: assert property (regWr && regAddr == drc_pkg::REG_STATUS
		&& regWdata == drc_pkg::CMD_RESTART |=> unloadRestart)
		else $error("unload restart missing");
	rate_lock_a: assert property (regWr && regAddr == drc_pkg::REG_RATE && !armed
		|=> $stable(rate))
		else $error("rate changed while triggered");
	edge_trig_a: assert property (tick && |hits && armed && !clearReq
		|=> state == drc_pkg::ST_POST)
		else $error("edge did not trigger");
	led_route_a: assert property (ready |=> ledReady == $past(ledRoute))
		else $error("lamp routing wrong");

	trig_seen_c:    cover property (trigReq ##[1:1000] ready);
	clear_seen_c:   cover property (ready ##1 clearReq);
	restart_seen_c: cover property (ready && unloadRestart);
endmodule // drc_recorder_ctrl

// ===== tb/disturbance_recorder_control_tb.sv
// self-checking bench for the disturbance recorder control block
`timescale 1ns/1ns
module disturbance_recorder_control_tb;
	logic                clk_sys;
	logic                rst;
	logic [3:0]          regAddr;
	logic [15:0]         regWdata;
	logic                regWr;
	logic                regRd;
	logic [15:0]         regRdata;
	logic [7:0]          intSig;
	logic [7:0]          dinSig;
	logic                masterReset;
	logic                displayIdle;
	drc_pkg::drc_event_t evOut;
	logic                memErase;
	logic                unloadRestart;
	logic                unloadReady;
	logic                readyMarker;
	logic [7:0]          ledReady;
	logic [7:0]          recSample;
	logic                recSampleValid;
	logic                rdPend = 1'b0;
	logic [15:0]         rdQ[$];
	logic [7:0]          evQ[$];
	logic [7:0]          led;
	int                  n_mismatch = 0;
	int                  n_compared = 0;
	int                  nErase = 0;
	int                  nRestart = 0;
	int                  cycles = 0;
	int                  k;

	// ------------------------------------------------------------
	// design and master
	// ------------------------------------------------------------
	drc_recorder_ctrl #(.DIV_HI(4), .DIV_MID(6), .DIV_RMS(8)) DUT (
		.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .intSig(intSig),
		.dinSig(dinSig), .masterReset(masterReset), .displayIdle(displayIdle),
		.evOut(evOut), .memErase(memErase), .unloadRestart(unloadRestart),
		.unloadReady(unloadReady), .recSample(recSample), .recSampleValid(recSampleValid),
		.readyMarker(readyMarker), .ledReady(ledReady));
	drc_master_model MST (.clk_sys(clk_sys), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd));

	// 100 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic rdChk(input logic [3:0] a, input logic [15:0] exp);
		rdQ.push_back(exp);
		MST.rd(a);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// bounded wait; post length is short so ready comes within a few ticks
	task automatic waitReady();
		for (int i = 0; i < 60 && readyMarker !== 1'b1; i++) @(negedge clk_sys);
	endtask

	// bounded wait for the next stored sample pulse
	task automatic waitSample();
		for (int i = 0; i < 40 && recSampleValid !== 1'b1; i++) @(negedge clk_sys);
	endtask

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// monitor: oldest note is taken whenever a result appears; also hang guard
	always @(posedge clk_sys) begin
		rdPend <= regRd;
		if (rdPend) chk("regRdata", regRdata, rdQ.size() ? rdQ.pop_front() : 16'hdead);
		if (evOut.valid === 1'b1) chk("evCode", {8'h00, evOut.code},
			evQ.size() ? {8'h00, evQ.pop_front()} : 16'hffff);
		if (memErase === 1'b1) nErase++;
		if (unloadRestart === 1'b1) nRestart++;
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			summarize();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		intSig = '0;
		dinSig = '0;
		masterReset = 1'b0;
		displayIdle = 1'b1;
		void'($urandom(3280));
		idle(4);
		rst <= 1'b0;
		rdChk(drc_pkg::REG_EVMASK, drc_pkg::EVMASK_RESET);
		rdChk(drc_pkg::REG_POSTLEN, drc_pkg::POSTLEN_RESET);
		rdChk(drc_pkg::REG_STATUS, drc_pkg::STATUS_IDLE);
		$display("test reset values done");
		// manual trigger through to ready, then a refused trigger and restart
		led = 8'($urandom()) | 8'h01;
		MST.wr(drc_pkg::REG_LEDROUTE, {8'h00, led});
		MST.wr(drc_pkg::REG_POSTLEN, 16'h0002);
		MST.prep();
		evQ.push_back(drc_pkg::EV_TRIGGER);
		MST.trig();
		rdChk(drc_pkg::REG_STATUS, drc_pkg::STATUS_IDLE);
		MST.wr(drc_pkg::REG_RATE, 16'h0001);
		rdChk(drc_pkg::REG_RATE, 16'h0000);
		waitReady();
		chk("readyMarker", readyMarker, 16'h0001);
		chk("ledReady", ledReady, led);
		chk("unloadReady", unloadReady, 16'h0001);
		chk("recSampleValid", recSampleValid, 16'h0000);
		rdChk(drc_pkg::REG_STATUS, drc_pkg::STATUS_READY);
		displayIdle <= 1'b0;
		idle(3);
		chk("readyMarker", readyMarker, 16'h0000);
		displayIdle <= 1'b1;
		dinSig <= 8'($urandom());
		MST.trig();
		rdChk(drc_pkg::REG_STATE, 16'h0004);
		MST.wr(drc_pkg::REG_STATUS, drc_pkg::CMD_RESTART);
		idle(2);
		chk("nRestart", 16'(nRestart), 16'h0001);
		evQ.push_back(drc_pkg::EV_CLEAR);
		MST.clear();
		idle(2);
		chk("nErase", 16'(nErase), 16'h0001);
		chk("readyMarker", readyMarker, 16'h0000);
		rdChk(drc_pkg::REG_STATUS, drc_pkg::STATUS_IDLE);
		$display("test manual trigger done");
		// signal triggers: falling edge on an internal signal, rising on an input
		dinSig <= 8'($urandom()) & 8'hfe;
		for (k = 0; k < 2; k++) begin
			MST.wr(k ? drc_pkg::REG_SRC_B : drc_pkg::REG_SRC_A, 16'h0001);
			MST.wr(k ? drc_pkg::REG_EDGE_B : drc_pkg::REG_EDGE_A, k ? 16'h0000 : 16'h0001);
			if (k == 0) begin
				intSig[0] <= 1'b1;
				idle(12);
				rdChk(drc_pkg::REG_STATE, 16'h0001);
				evQ.push_back(drc_pkg::EV_TRIGGER);
				intSig[0] <= 1'b0;
			end else begin
				evQ.push_back(drc_pkg::EV_TRIGGER);
				dinSig[0] <= 1'b1;
			end
			waitReady();
			rdChk(drc_pkg::REG_STATUS, drc_pkg::STATUS_READY);
			MST.wr(k ? drc_pkg::REG_SRC_B : drc_pkg::REG_SRC_A, 16'h0000);
			evQ.push_back(drc_pkg::EV_CLEAR);
			MST.clear();
			dinSig[0] <= 1'b0;
		end
		$display("test edge triggers done");
		// masked trigger event, then master reset
		MST.wr(drc_pkg::REG_EVMASK, 16'h0002);
		MST.trig();
		idle(2);
		rdChk(drc_pkg::REG_STATE, 16'h0002);
		evQ.push_back(drc_pkg::EV_CLEAR);
		masterReset <= 1'b1;
		idle(1);
		masterReset <= 1'b0;
		idle(2);
		chk("nErase", 16'(nErase), 16'h0004);
		rdChk(drc_pkg::REG_STATE, 16'h0001);
		MST.wr(drc_pkg::REG_RATE, 16'h0002);
		rdChk(drc_pkg::REG_RATE, 16'h0002);
		idle(4);
		chk("evQueue", 16'(evQ.size()), 16'h0000);
		$display("test mask and master reset done");
		// channel pick: nine selected, four internal kept first, last input dropped
		MST.wr(drc_pkg::REG_RATE, 16'h0001);
		rdChk(drc_pkg::REG_RATE, 16'h0001);
		MST.wr(drc_pkg::REG_CH_INT, 16'h00f0);
		MST.wr(drc_pkg::REG_CH_DIN, 16'h001f);
		intSig <= 8'($urandom());
		dinSig <= 8'($urandom());
		idle(8);
		waitSample();
		chk("recSampleValid", recSampleValid, 16'h0001);
		chk("recSample", recSample, {8'h00, dinSig[3:0], intSig[7:4]});
		$display("test channel pick done");
		summarize();
	end
endmodule // disturbance_recorder_control_tb

// ===== tb/drc_master_model.sv
// register bus master standing in for the serial parameter master
`timescale 1ns/1ns
module drc_master_model (
	// clock
	input  wire logic                       clk_sys,
	// register port
	output logic      [drc_pkg::ADDR_W-1:0] regAddr,
	output logic      [drc_pkg::DATA_W-1:0] regWdata,
	output logic                            regWr,
	output logic                            regRd
);
	// ------------------------------------------------------------
	// bus cycles
	// ------------------------------------------------------------
	// idle bus at time zero
	initial begin
		regAddr = '0;
		regWdata = '0;
		regWr = 1'b0;
		regRd = 1'b0;
	end

	// one write cycle; released lines carry inverted leftovers, never held values
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
		regAddr <= ~a;
		regWdata <= ~d;
	endtask

	// one read cycle; data is picked up by the bench monitor
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		regAddr <= ~a;
	endtask

	// ------------------------------------------------------------
	// commands
	// ------------------------------------------------------------
	// manual trigger command
	task automatic trig();
		wr(drc_pkg::REG_MANTRIG, drc_pkg::CMD_TRIGGER);
	endtask

	// clear recorder memory and re-arm
	task automatic clear();
		wr(drc_pkg::REG_CLRARM, drc_pkg::CMD_CLEAR);
	endtask

	// both unload prerequisites before any upload
	task automatic prep();
		wr(drc_pkg::REG_PREREQ1, 16'h0001);
		wr(drc_pkg::REG_PREREQ2, 16'h0001);
	endtask
endmodule // drc_master_model
